// ==== hw/tmr_pkg.sv ====
// types of the tunnel mode relay framer
package tmr_pkg;
  typedef enum logic [2:0] {
    M_RX = 3'b000,
    M_WPOLL = 3'b001,
    M_POLL_TX = 3'b010,
    M_WANS = 3'b011,
    M_ANS_DATA = 3'b100,
    M_ACK_TX = 3'b101,
    M_RF_TX = 3'b110
  } tmr_st_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0000,
    RX_ID = 4'b0001,
    RX_K = 4'b0010,
    RX_SVC = 4'b0011,
    RX_M = 4'b0100,
    RX_BLK = 4'b0101,
    RX_DATA = 4'b0110,
    RX_INS = 4'b0111,
    RX_P1 = 4'b1000,
    RX_P2 = 4'b1001,
    RX_LEN = 4'b1010,
    RX_END = 4'b1011
  } tmr_rx_t;
endpackage

// ==== hw/tmr_regs.svh ====
// constants of the tunnel mode relay framer
// Behaviour
// - a card-format read reply is code 07h, card id, two flags, block count, 16 bytes per block.
// - a card-format read reply drops block count and data unless the status is normal.
// - an apdu read reply is 1 to 251 data bytes then SW1 SW2, data dropped on error.
// - a card write with a service count outside 1 to 11 gets an error reply.
// - service codes are ignored, but unequal codes in one write give an error.
// - write block count is 1 to 12 with up to 8 services and 1 to 11 with 9 to 11.
// - an apdu write is class 00h, instruction D6h, P1 P2 address, Lc, data; other class errs.
// - apdu write length is 1 to 248 and a multiple of 16 when encrypted.
// - the host polls with 28h and gets a code and a big-endian start address.
// - the poll reply then has a length byte n, and for a write also the n bytes to write.
// - a card-format write reply is code 09h, the 8-byte id and two flags, no data.
// - the host closes with F8h for normal end or E8h for error and gets one status byte.
// - an apdu read asks 1 to 251 bytes and the host answer brings that range.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_CMD_RD 8'h06
`define TMR_CMD_WR 8'h08
`define TMR_RSP_RD 8'h07
`define TMR_RSP_WR 8'h09
`define TMR_CLA 8'h00
`define TMR_INS_RD 8'hb0
`define TMR_INS_WR 8'hd6
`define TMR_POLL 8'h28
`define TMR_ANS_OK 8'hf8
`define TMR_ANS_ERR 8'he8
`define TMR_K_MAX_RD 8'h0f
`define TMR_K_MAX_WR 8'h0b
`define TMR_K_SPLIT 8'h08
`define TMR_M_MAX_RD 8'h0f
`define TMR_M_MAX_LO 8'h0c
`define TMR_M_MAX_HI 8'h0b
`define TMR_LE_MAX 8'hfb
`define TMR_LC_MAX 8'hf8
`define TMR_FLAG1_OK 8'h00
`define TMR_FLAG2_OK 8'h00
`define TMR_FLAG1_ERR 8'hff
`define TMR_FLAG2_ERR 8'h70
`define TMR_SW1_OK 8'h90
`define TMR_SW2_OK 8'h00
`define TMR_SW1_ERR 8'h6a
`define TMR_SW2_ERR 8'h82
`define TMR_ST_RD_DET 8'h01
`define TMR_ST_WR_DET 8'h02
`define TMR_ST_ACK 8'h00
`define TMR_CARD_HDR 9'h00b
`define TMR_APDU_TAIL 9'h002
`define TMR_POLL_HDR 9'h004
`endif

// ==== hw/tmr_relay.sv ====
// tunnel mode relay framer between rf reader and host
`timescale 1ns/1ps
`default_nettype none
`include "tmr_regs.svh"
module tmr_relay (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rf_apdu,
  input wire logic rf_encrypted,
  input wire logic rf_rx_valid,
  input wire logic [7:0] rf_rx_data,
  input wire logic rf_rx_last,
  input wire logic rf_tx_ready,
  input wire logic host_rx_valid,
  input wire logic [7:0] host_rx_data,
  input wire logic host_tx_ready,
  output logic rf_tx_valid,
  output logic [7:0] rf_tx_data,
  output logic rf_tx_last,
  output logic host_tx_valid,
  output logic [7:0] host_tx_data,
  output logic host_tx_last,
  output logic tunnel_busy
);
  tmr_pkg::tmr_st_t st_r, st_nxt;
  tmr_pkg::tmr_rx_t rx_r, rx_nxt;
  logic err_r, err_nxt, frame_ok;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] eb_r, eb_nxt, elen_r, elen_nxt;
  logic apdu_r, is_wr_r, res_ok_r, busy_r;
  logic [7:0] k_r, m_r, len_r, addr_hi_r, addr_lo_r, ans_cnt_r;
  logic [15:0] svc0_r;
  logic [7:0] id_r [0:7];
  logic [7:0] buf_r [0:255];
  logic [8:0] rf_idx, host_idx;
  logic rf_done, host_done;

  wire [7:0] d = rf_rx_data;
  wire rx_take = (st_r == tmr_pkg::M_RX) & rf_rx_valid;
  wire frame_end = rx_take & rf_rx_last;
  wire k_bad = (d == 8'h00) | (d > (is_wr_r ? `TMR_K_MAX_WR : `TMR_K_MAX_RD));
  wire [7:0] m_max = !is_wr_r ? `TMR_M_MAX_RD :
    (k_r > `TMR_K_SPLIT) ? `TMR_M_MAX_HI : `TMR_M_MAX_LO;
  wire m_bad = (d == 8'h00) | (d > m_max);
  // only the first code is kept; later ones must match it byte for byte
  wire svc_bad = (cnt_r >= 8'h02) & (d != (cnt_r[0] ? svc0_r[15:8] : svc0_r[7:0]));
  wire svc_end = cnt_r == 8'({k_r[6:0], 1'b0} - 8'h01);
  wire le_bad = (d == 8'h00) | (d > `TMR_LE_MAX);
  wire lc_bad = (d == 8'h00) | (d > `TMR_LC_MAX) | (rf_encrypted & (d[3:0] != 4'h0));
  wire elem_end = (eb_r != 2'b00) & (eb_r == elen_r);
  wire data_end = cnt_r == 8'(len_r - 8'h01);

  // frame parser; after any fault the rest of the frame is swallowed
  always_comb begin
    rx_nxt = rx_r;
    err_nxt = err_r;
    cnt_nxt = cnt_r;
    eb_nxt = eb_r;
    elen_nxt = elen_r;
    frame_ok = 1'b0;
    if (rx_take) begin
      unique case (rx_r)
        tmr_pkg::RX_IDLE: begin
          cnt_nxt = 8'h00;
          if (rf_apdu) begin
            rx_nxt = tmr_pkg::RX_INS;
            err_nxt = d != `TMR_CLA;
          end else begin
            rx_nxt = tmr_pkg::RX_ID;
            err_nxt = (d != `TMR_CMD_RD) & (d != `TMR_CMD_WR);
          end
        end
        tmr_pkg::RX_ID: begin
          cnt_nxt = cnt_r + 8'h01;
          if (cnt_r == 8'h07) begin
            rx_nxt = tmr_pkg::RX_K;
          end
        end
        tmr_pkg::RX_K: begin
          cnt_nxt = 8'h00;
          err_nxt = k_bad;
          rx_nxt = tmr_pkg::RX_SVC;
        end
        tmr_pkg::RX_SVC: begin
          err_nxt = svc_bad;
          cnt_nxt = cnt_r + 8'h01;
          if (svc_end) begin
            rx_nxt = tmr_pkg::RX_M;
          end
        end
        tmr_pkg::RX_M: begin
          err_nxt = m_bad;
          cnt_nxt = 8'h00;
          eb_nxt = 2'b00;
          rx_nxt = tmr_pkg::RX_BLK;
        end
        tmr_pkg::RX_BLK: begin
          eb_nxt = eb_r + 2'b01;
          if (eb_r == 2'b00) begin
            // top bit marks a two-byte element
            elen_nxt = d[7] ? 2'b01 : 2'b10;
          end
          if (elem_end) begin
            eb_nxt = 2'b00;
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == 8'(m_r - 8'h01)) begin
              cnt_nxt = 8'h00;
              rx_nxt = is_wr_r ? tmr_pkg::RX_DATA : tmr_pkg::RX_END;
            end
          end
        end
        tmr_pkg::RX_DATA: begin
          cnt_nxt = cnt_r + 8'h01;
          if (data_end) begin
            rx_nxt = tmr_pkg::RX_END;
          end
        end
        tmr_pkg::RX_INS: begin
          err_nxt = (d != `TMR_INS_RD) & (d != `TMR_INS_WR);
          rx_nxt = tmr_pkg::RX_P1;
        end
        tmr_pkg::RX_P1: rx_nxt = tmr_pkg::RX_P2;
        tmr_pkg::RX_P2: rx_nxt = tmr_pkg::RX_LEN;
        tmr_pkg::RX_LEN: begin
          err_nxt = is_wr_r ? lc_bad : le_bad;
          cnt_nxt = 8'h00;
          rx_nxt = is_wr_r ? tmr_pkg::RX_DATA : tmr_pkg::RX_END;
        end
        tmr_pkg::RX_END: begin
        end
        default: rx_nxt = tmr_pkg::RX_END;
      endcase
      if (err_nxt) begin
        rx_nxt = tmr_pkg::RX_END;
      end
      // a short frame never reaches the end state and is refused too
      frame_ok = rf_rx_last & ~err_nxt & (rx_nxt == tmr_pkg::RX_END);
      if (rf_rx_last) begin
        rx_nxt = tmr_pkg::RX_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_r <= tmr_pkg::RX_IDLE;
      err_r <= 1'b0;
      cnt_r <= 8'h00;
      eb_r <= 2'b00;
      elen_r <= 2'b00;
    end else begin
      rx_r <= rx_nxt;
      err_r <= err_nxt;
      cnt_r <= cnt_nxt;
      eb_r <= eb_nxt;
      elen_r <= elen_nxt;
    end
  end

  // field capture
  always_ff @(posedge clk) begin
    if (!nrst) begin
      apdu_r <= 1'b0;
      is_wr_r <= 1'b0;
      k_r <= 8'h00;
      m_r <= 8'h00;
      len_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_lo_r <= 8'h00;
      svc0_r <= 16'h0000;
    end else if (rx_take) begin
      unique case (rx_r)
        tmr_pkg::RX_IDLE: begin
          apdu_r <= rf_apdu;
          is_wr_r <= ~rf_apdu & (d == `TMR_CMD_WR);
        end
        tmr_pkg::RX_K: k_r <= d;
        tmr_pkg::RX_SVC: begin
          if (cnt_r == 8'h00) svc0_r[7:0] <= d;
          if (cnt_r == 8'h01) svc0_r[15:8] <= d;
        end
        tmr_pkg::RX_M: begin
          m_r <= d;
          len_r <= {d[3:0], 4'h0};
        end
        tmr_pkg::RX_BLK: begin
          if (cnt_r == 8'h00 && eb_r == 2'b00) addr_hi_r <= 8'h00;
          if (cnt_r == 8'h00 && eb_r == 2'b01) addr_lo_r <= d;
          if (cnt_r == 8'h00 && eb_r == 2'b10) addr_hi_r <= d;
        end
        tmr_pkg::RX_INS: is_wr_r <= d == `TMR_INS_WR;
        tmr_pkg::RX_P1: addr_hi_r <= d;
        tmr_pkg::RX_P2: addr_lo_r <= d;
        tmr_pkg::RX_LEN: len_r <= d;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rx_take && rx_r == tmr_pkg::RX_ID) begin
      id_r[cnt_r[2:0]] <= d;
    end
  end

  // host side decode
  wire poll_hit = (st_r == tmr_pkg::M_WPOLL) & host_rx_valid & (host_rx_data == `TMR_POLL);
  wire ans_in = (st_r == tmr_pkg::M_WANS) & host_rx_valid;
  wire ans_ok_hit = ans_in & (host_rx_data == `TMR_ANS_OK);
  wire ans_err_hit = ans_in & (host_rx_data == `TMR_ANS_ERR);
  wire ans_byte = (st_r == tmr_pkg::M_ANS_DATA) & host_rx_valid;
  wire ans_last = ans_byte & (ans_cnt_r == 8'(len_r - 8'h01));
  wire ack_go = ans_err_hit | (ans_ok_hit & is_wr_r) | ans_last;
  wire host_start = poll_hit | ack_go;
  wire rf_start = (frame_end & ~frame_ok) | ((st_r == tmr_pkg::M_ACK_TX) & host_done);
  wire res_set = (ans_ok_hit & is_wr_r) | ans_last;
  wire res_clr = ans_err_hit | (frame_end & ~frame_ok);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      tmr_pkg::M_RX: if (frame_end) st_nxt = frame_ok ? tmr_pkg::M_WPOLL : tmr_pkg::M_RF_TX;
      tmr_pkg::M_WPOLL: if (poll_hit) st_nxt = tmr_pkg::M_POLL_TX;
      tmr_pkg::M_POLL_TX: if (host_done) st_nxt = tmr_pkg::M_WANS;
      tmr_pkg::M_WANS: begin
        if (ack_go) st_nxt = tmr_pkg::M_ACK_TX;
        else if (ans_ok_hit) st_nxt = tmr_pkg::M_ANS_DATA;
      end
      tmr_pkg::M_ANS_DATA: if (ans_last) st_nxt = tmr_pkg::M_ACK_TX;
      tmr_pkg::M_ACK_TX: if (host_done) st_nxt = tmr_pkg::M_RF_TX;
      tmr_pkg::M_RF_TX: if (rf_done) st_nxt = tmr_pkg::M_RX;
      default: st_nxt = tmr_pkg::M_RX;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= tmr_pkg::M_RX;
      busy_r <= 1'b0;
      res_ok_r <= 1'b0;
      ans_cnt_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      busy_r <= st_nxt != tmr_pkg::M_RX;
      if (res_set) res_ok_r <= 1'b1;
      else if (res_clr) res_ok_r <= 1'b0;
      if (ans_ok_hit) ans_cnt_r <= 8'h00;
      else if (ans_byte) ans_cnt_r <= ans_cnt_r + 8'h01;
    end
  end
  assign tunnel_busy = busy_r;

  // one store serves write data from rf and read data from host
  always_ff @(posedge clk) begin
    if (rx_take && rx_r == tmr_pkg::RX_DATA) begin
      buf_r[cnt_r] <= d;
    end else if (ans_byte) begin
      buf_r[ans_cnt_r] <= host_rx_data;
    end
  end

  // reply to the reader
  wire rd_ok = res_ok_r & ~is_wr_r;
  wire [8:0] len9 = {1'b0, len_r};
  wire [8:0] data_n = rd_ok ? len9 : 9'h000;
  wire [8:0] rf_len = apdu_r ? data_n + `TMR_APDU_TAIL :
    rd_ok ? len9 + `TMR_CARD_HDR + 9'h001 : `TMR_CARD_HDR;
  wire [8:0] ri = rf_idx;
  wire [7:0] id_b = id_r[3'(ri - 9'h001)];
  wire [7:0] card_b = (ri == 9'h000) ? (is_wr_r ? `TMR_RSP_WR : `TMR_RSP_RD) :
    (ri <= 9'h008) ? id_b :
    (ri == 9'h009) ? (res_ok_r ? `TMR_FLAG1_OK : `TMR_FLAG1_ERR) :
    (ri == 9'h00a) ? (res_ok_r ? `TMR_FLAG2_OK : `TMR_FLAG2_ERR) :
    (ri == 9'h00b) ? m_r : buf_r[8'(ri - 9'h00c)];
  wire [7:0] apdu_b = (ri < data_n) ? buf_r[ri[7:0]] :
    (ri == data_n) ? (res_ok_r ? `TMR_SW1_OK : `TMR_SW1_ERR) :
    (res_ok_r ? `TMR_SW2_OK : `TMR_SW2_ERR);
  wire [7:0] rf_byte = apdu_r ? apdu_b : card_b;

  // frames to the host: poll reply, then answer ack
  wire in_poll = st_r == tmr_pkg::M_POLL_TX;
  wire [15:0] host_addr = apdu_r ? {addr_hi_r, addr_lo_r} :
    {addr_hi_r[3:0], addr_lo_r, 4'h0};
  wire [8:0] host_len = !in_poll ? 9'h001 :
    is_wr_r ? len9 + `TMR_POLL_HDR : `TMR_POLL_HDR;
  wire [8:0] hi = host_idx;
  wire [7:0] poll_b = (hi == 9'h000) ? (is_wr_r ? `TMR_ST_WR_DET : `TMR_ST_RD_DET) :
    (hi == 9'h001) ? host_addr[15:8] :
    (hi == 9'h002) ? host_addr[7:0] :
    (hi == 9'h003) ? len_r : buf_r[8'(hi - 9'h004)];
  wire [7:0] host_byte = in_poll ? poll_b : `TMR_ST_ACK;

  tmr_tx u_rf_tx (
    .clk(clk),
    .nrst(nrst),
    .start(rf_start),
    .len(rf_len),
    .byte_in(rf_byte),
    .ready(rf_tx_ready),
    .idx(rf_idx),
    .valid(rf_tx_valid),
    .data(rf_tx_data),
    .last(rf_tx_last),
    .done(rf_done)
  );

  tmr_tx u_host_tx (
    .clk(clk),
    .nrst(nrst),
    .start(host_start),
    .len(host_len),
    .byte_in(host_byte),
    .ready(host_tx_ready),
    .idx(host_idx),
    .valid(host_tx_valid),
    .data(host_tx_data),
    .last(host_tx_last),
    .done(host_done)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_rf_reply_code: assert property (rf_start |-> ##2 rf_tx_valid &&
    (apdu_r || rf_tx_data == (is_wr_r ? 8'h09 : 8'h07)))
    else $error("wrong rf reply code");
  a_card_rd_len: assert property (rf_tx_valid && rf_tx_last && !apdu_r && rd_ok
    |-> rf_idx == len9 + 9'h00c)
    else $error("card read reply length wrong");
  a_card_short_len: assert property (rf_tx_valid && rf_tx_last && !apdu_r && !rd_ok
    |-> rf_idx == 9'h00b)
    else $error("card reply not cut to header");
  a_apdu_len: assert property (rf_tx_valid && rf_tx_last && apdu_r
    |-> rf_idx == (rd_ok ? len9 + 9'h002 : 9'h002))
    else $error("apdu reply length wrong");
  a_svc_count: assert property (rx_take && rx_r == tmr_pkg::RX_K && is_wr_r &&
    (d == 8'h00 || d > 8'h0b) && !rf_rx_last |=> rx_r == tmr_pkg::RX_END)
    else $error("bad service count accepted");
  a_svc_equal: assert property (rx_take && rx_r == tmr_pkg::RX_SVC && svc_bad
    |-> !frame_ok ##1 (err_r || rx_r == tmr_pkg::RX_IDLE))
    else $error("unequal service codes accepted");
  a_blk_count: assert property (rx_take && rx_r == tmr_pkg::RX_M && is_wr_r &&
    k_r > 8'h08 && d == 8'h0c |-> err_nxt)
    else $error("twelve blocks taken with many services");
  a_apdu_class: assert property (rx_take && rx_r == tmr_pkg::RX_IDLE && rf_apdu &&
    d != 8'h00 && rf_rx_last |=> st_r == tmr_pkg::M_RF_TX)
    else $error("bad class not refused");
  a_lc_check: assert property (rx_take && rx_r == tmr_pkg::RX_LEN && is_wr_r &&
    rf_encrypted && d[3:0] != 4'h0 |-> !frame_ok)
    else $error("encrypted length not multiple of 16");
  a_poll_reply: assert property (poll_hit |-> ##2 host_tx_valid &&
    host_tx_data == (is_wr_r ? 8'h02 : 8'h01))
    else $error("poll reply code wrong");
  a_poll_len: assert property (host_tx_valid && host_tx_last && in_poll
    |-> host_idx == (is_wr_r ? len9 + 9'h004 : 9'h004))
    else $error("poll reply length wrong");
  a_ans_ack: assert property (ack_go |-> ##2 host_tx_valid && host_tx_last &&
    host_tx_data == 8'h00)
    else $error("answer not acknowledged");
  a_err_answer: assert property (ans_err_hit |=> (!res_ok_r)[*3])
    else $error("error answer reported as normal");

  c_write_done: cover property (ans_ok_hit && is_wr_r ##[1:600] rf_done);
  c_read_done: cover property (ans_last ##[1:600] rf_done);
  c_frame_err: cover property (frame_end && !frame_ok);
  c_host_err: cover property (ans_err_hit);
endmodule
`default_nettype wire

// ==== hw/tmr_tx.sv ====
// byte frame sender with valid/ready handshake
`timescale 1ns/1ps
`default_nettype none
module tmr_tx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [8:0] len,
  input wire logic [7:0] byte_in,
  input wire logic ready,
  output logic [8:0] idx,
  output logic valid,
  output logic [7:0] data,
  output logic last,
  output logic done
);
  logic busy_r;
  logic [8:0] cnt_r;
  wire take = valid & ready;
  wire load = busy_r & (~valid | ready);
  wire at_end = cnt_r == 9'(len - 9'h001);
  assign idx = cnt_r;
  assign done = take & last;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 9'h000;
      valid <= 1'b0;
      data <= 8'h00;
      last <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
      cnt_r <= 9'h000;
      valid <= 1'b0;
    end else if (load) begin
      valid <= 1'b1;
      data <= byte_in;
      last <= at_end;
      cnt_r <= cnt_r + 9'h001;
      busy_r <= ~at_end;
    end else if (take) begin
      valid <= 1'b0;
    end
  end
  // a byte stays offered until the sink takes it
  a_tx_hold_byte: assert property (@(posedge clk) disable iff (!nrst)
    valid && !ready && !start |=> valid && $stable(data))
    else $error("tx byte dropped before ready");
endmodule
`default_nettype wire

// ==== sim/tmr_host_model.sv ====
// behavioural host that polls, answers and takes bytes from the relay
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
  input wire logic clk,
  input wire logic tunnel_busy,
  input wire logic host_tx_valid,
  input wire logic [7:0] host_tx_data,
  input wire logic host_tx_last,
  output logic host_rx_valid,
  output logic [7:0] host_rx_data,
  output logic host_tx_ready
);
  typedef logic [7:0] tmr_hq_t[$];
  initial begin
    host_rx_valid = 1'b0;
    host_rx_data = 8'h00;
    host_tx_ready = 1'b0;
  end
  // released line shows the inverse so stale data is never mistaken
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    host_rx_valid = 1'b1;
    host_rx_data = b;
    @(negedge clk);
    host_rx_valid = 1'b0;
    host_rx_data = ~b;
  endtask
  // slow stalls ready every other cycle
  task automatic take(input bit slow, output tmr_hq_t q, output bit ok);
    q = {};
    ok = 1'b0;
    for (int n = 0; n < 2000 && !ok; n++) begin
      @(negedge clk);
      host_tx_ready = slow ? ~host_tx_ready : 1'b1;
      @(posedge clk);
      if (host_tx_valid && host_tx_ready) begin
        q.push_back(host_tx_data);
        ok = host_tx_last;
      end
    end
    @(negedge clk);
    host_tx_ready = 1'b0;
  endtask
  task automatic run(input logic [7:0] ans, input int n, input bit slow,
    output tmr_hq_t pq, output tmr_hq_t aq, output bit ok);
    bit ok0;
    bit ok1;
    bit ok2;
    for (int i = 0; i < 200 && !tunnel_busy; i++) @(negedge clk);
    // a frame that never raises busy counts as a hang
    ok0 = tunnel_busy;
    repeat (2) @(negedge clk);
    put(8'h28);
    take(slow, pq, ok1);
    repeat (2) @(negedge clk);
    put(ans);
    if (ans == 8'hf8) for (int i = 0; i < n; i++) put(8'hd0 + 8'(i));
    take(slow, aq, ok2);
    ok = ok0 && ok1 && ok2;
  endtask
endmodule
`default_nettype wire

// ==== sim/tmr_relay_tb_top.sv ====
// self-checking bench for the tunnel relay framer
`timescale 1ns/1ps
`default_nettype none
module tunnel_mode_relay_frames_tb_top;
  typedef logic [7:0] tmr_q_t[$];
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rf_apdu = 1'b0;
  logic rf_encrypted = 1'b0;
  logic rf_rx_valid = 1'b0;
  logic [7:0] rf_rx_data = 8'h00;
  logic rf_rx_last = 1'b0;
  logic rf_tx_ready = 1'b0;
  logic host_rx_valid, host_tx_ready, rf_tx_valid, rf_tx_last;
  logic host_tx_valid, host_tx_last, tunnel_busy;
  logic [7:0] host_rx_data, rf_tx_data, host_tx_data;
  int failures = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  tmr_relay dut (.clk(clk), .nrst(nrst), .rf_apdu(rf_apdu), .rf_encrypted(rf_encrypted),
    .rf_rx_valid(rf_rx_valid), .rf_rx_data(rf_rx_data), .rf_rx_last(rf_rx_last),
    .rf_tx_ready(rf_tx_ready), .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
    .host_tx_ready(host_tx_ready), .rf_tx_valid(rf_tx_valid), .rf_tx_data(rf_tx_data),
    .rf_tx_last(rf_tx_last), .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
    .host_tx_last(host_tx_last), .tunnel_busy(tunnel_busy));
  tmr_host_model host (.clk(clk), .tunnel_busy(tunnel_busy), .host_tx_valid(host_tx_valid),
    .host_tx_data(host_tx_data), .host_tx_last(host_tx_last), .host_rx_valid(host_rx_valid),
    .host_rx_data(host_rx_data), .host_tx_ready(host_tx_ready));
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic fail_out();
    failures++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpq(input tmr_q_t g, input tmr_q_t e);
    chk(8'(g.size()), 8'(e.size()));
    foreach (e[i]) if (i < g.size()) chk(g[i], e[i]);
  endtask
  function automatic tmr_q_t seq(input logic [7:0] b, input int n);
    tmr_q_t q;
    for (int i = 0; i < n; i++) q.push_back(b + 8'(i));
    return q;
  endfunction
  // card frame with 2-byte block elements; hi2 sets the second service code
  function automatic tmr_q_t card(input logic [7:0] cmd, k, hi2, m);
    tmr_q_t q;
    q = {cmd, seq(8'ha0, 8), k};
    for (int i = 0; i < k; i++) q = {q, 8'h00, (i == 1) ? hi2 : 8'h09};
    q.push_back(m);
    for (int i = 0; i < m; i++) q = {q, 8'h80, 8'h05 + 8'(i)};
    if (cmd == 8'h08) q = {q, seq(8'h40, 16 * m)};
    return q;
  endfunction
  function automatic tmr_q_t rsp(input logic [7:0] code, f1, f2);
    rsp = {code, seq(8'ha0, 8), f1, f2};
  endfunction
  task automatic send_rf(input bit apdu, input bit enc, input tmr_q_t f);
    foreach (f[i]) begin
      @(negedge clk);
      rf_apdu = apdu;
      rf_encrypted = enc;
      rf_rx_valid = 1'b1;
      rf_rx_data = f[i];
      rf_rx_last = (i == f.size() - 1);
    end
    @(negedge clk);
    rf_rx_valid = 1'b0;
    rf_rx_last = 1'b0;
    rf_rx_data = ~rf_rx_data;
  endtask
  // reader stalls ready every other cycle
  task automatic get_rf(output tmr_q_t q);
    bit done;
    done = 1'b0;
    q = {};
    for (int n = 0; n < 2000 && !done; n++) begin
      @(negedge clk);
      rf_tx_ready = ~rf_tx_ready;
      @(posedge clk);
      if (rf_tx_valid && rf_tx_ready) begin
        q.push_back(rf_tx_data);
        done = rf_tx_last;
      end
    end
    @(negedge clk);
    rf_tx_ready = 1'b0;
    if (!done) fail_out();
  endtask
  // a stray frame while busy must vanish without a reply
  task automatic tunnel(input bit apdu, input tmr_q_t f, input logic [7:0] ans, input int n,
    input tmr_q_t poll_e, input tmr_q_t rf_e);
    tmr_q_t pq, aq, rq;
    bit ok;
    send_rf(apdu, 1'b0, f);
    send_rf(1'b0, 1'b0, {8'h06});
    host.run(ans, n, 1'b1, pq, aq, ok);
    if (!ok) fail_out();
    cmpq(pq, poll_e);
    cmpq(aq, {8'h00});
    get_rf(rq);
    cmpq(rq, rf_e);
    repeat (2) @(negedge clk);
    chk({7'h00, tunnel_busy}, 8'h00);
  endtask
  task automatic refuse(input bit apdu, input bit enc, input tmr_q_t f, input tmr_q_t e);
    tmr_q_t rq;
    send_rf(apdu, enc, f);
    get_rf(rq);
    cmpq(rq, e);
    chk({7'h00, tunnel_busy}, 8'h00);
  endtask
  task automatic sc_card_read();
    tunnel(1'b0, card(8'h06, 8'h01, 8'h09, 8'h01), 8'hf8, 16, {8'h01, 8'h00, 8'h50, 8'h10},
      {rsp(8'h07, 8'h00, 8'h00), 8'h01, seq(8'hd0, 16)});
    tunnel(1'b0, card(8'h06, 8'h01, 8'h09, 8'h01), 8'he8, 0, {8'h01, 8'h00, 8'h50, 8'h10},
      rsp(8'h07, 8'hff, 8'h70));
  endtask
  task automatic sc_card_write();
    tunnel(1'b0, card(8'h08, 8'h02, 8'h09, 8'h01), 8'hf8, 0,
      {8'h02, 8'h00, 8'h50, 8'h10, seq(8'h40, 16)}, rsp(8'h09, 8'h00, 8'h00));
    // three-byte element: block 0234h gives byte address 2340h
    tunnel(1'b0, {8'h08, seq(8'ha0, 8), 8'h01, 8'h00, 8'h09, 8'h01, 8'h00, 8'h34, 8'h02,
      seq(8'h40, 16)}, 8'hf8, 0, {8'h02, 8'h23, 8'h40, 8'h10, seq(8'h40, 16)},
      rsp(8'h09, 8'h00, 8'h00));
  endtask
  task automatic sc_card_refuse();
    refuse(1'b0, 1'b0, card(8'h08, 8'h00, 8'h09, 8'h01), rsp(8'h09, 8'hff, 8'h70));
    refuse(1'b0, 1'b0, card(8'h08, 8'h0c, 8'h09, 8'h01), rsp(8'h09, 8'hff, 8'h70));
    refuse(1'b0, 1'b0, card(8'h08, 8'h02, 8'h0a, 8'h01), rsp(8'h09, 8'hff, 8'h70));
    refuse(1'b0, 1'b0, card(8'h08, 8'h01, 8'h09, 8'h0d), rsp(8'h09, 8'hff, 8'h70));
    refuse(1'b0, 1'b0, card(8'h08, 8'h09, 8'h09, 8'h0c), rsp(8'h09, 8'hff, 8'h70));
    refuse(1'b0, 1'b0, card(8'h06, 8'h01, 8'h09, 8'h10), rsp(8'h07, 8'hff, 8'h70));
  endtask
  task automatic sc_apdu();
    tunnel(1'b1, {8'h00, 8'hd6, 8'h01, 8'h20, 8'hf8, seq(8'h00, 248)}, 8'hf8, 0,
      {8'h02, 8'h01, 8'h20, 8'hf8, seq(8'h00, 248)}, {8'h90, 8'h00});
    tunnel(1'b1, {8'h00, 8'hb0, 8'h00, 8'h10, 8'hfb}, 8'hf8, 251,
      {8'h01, 8'h00, 8'h10, 8'hfb}, {seq(8'hd0, 251), 8'h90, 8'h00});
    tunnel(1'b1, {8'h00, 8'hb0, 8'h00, 8'h10, 8'h03}, 8'he8, 0,
      {8'h01, 8'h00, 8'h10, 8'h03}, {8'h6a, 8'h82});
  endtask
  task automatic sc_apdu_refuse();
    refuse(1'b1, 1'b0, {8'h01, 8'hd6, 8'h00, 8'h00, 8'h01, 8'haa}, {8'h6a, 8'h82});
    refuse(1'b1, 1'b0, {8'h01}, {8'h6a, 8'h82});
    refuse(1'b1, 1'b0, {8'h00, 8'hd6, 8'h00, 8'h00, 8'h00}, {8'h6a, 8'h82});
    refuse(1'b1, 1'b0, {8'h00, 8'hd6, 8'h00, 8'h00, 8'hf9, seq(8'h00, 249)},
      {8'h6a, 8'h82});
    refuse(1'b1, 1'b1, {8'h00, 8'hd6, 8'h00, 8'h00, 8'h02, 8'haa, 8'hbb},
      {8'h6a, 8'h82});
    refuse(1'b1, 1'b0, {8'h00, 8'hb0, 8'h00, 8'h00, 8'h00}, {8'h6a, 8'h82});
    refuse(1'b1, 1'b0, {8'h00, 8'hb0, 8'h00, 8'h00, 8'hfc}, {8'h6a, 8'h82});
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    sc_card_read();
    sc_card_write();
    sc_card_refuse();
    sc_apdu();
    sc_apdu_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
